// ### logic/sdr_dev.sv
// flash disk end: sector dma request control with its registers
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - sectors field holds sector count minus one
// - read value zero means one sector left
// - decrement after each sector checksum read
// - ecc fault leaves remaining sector count intact
// - polarity zero: idle high, active low
// - polarity one: idle low, active high
// - pulse mode: one 300 ns (three clock) request pulse
// - level mode: release at deassert point
// - ecc fault during dma sets pause, stops
// - software fixes data, clears pause to resume
// - enable bit arms dma; clear means no requests
// - deassert point compared against byte counter
// - dma completion is a maskable interrupt source
// - ecc error is a separate interrupt source
module sdr_dev #(
  parameter int BUS_BYTES = 2                    // bus_cycle_byte_width
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  sdr_if.dev                          link,
  input  wire logic [8*BUS_BYTES-1:0] i_flash_data, // next word from the page buffer
  input  wire logic                   i_ecc_err,    // checksum check failed, with last beat
  output logic                        o_irq,        // level interrupt
  output logic                        o_busy        // dma armed and not paused
);
  import sdr_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  localparam logic [9:0] STEP = 10'(BUS_BYTES);
  logic                   dma_en;          // transfer enable
  logic                   pause;           // stopped on ecc fault
  logic                   pulse_sel;       // pulse or level request
  logic                   req_pol;         // request_polarity_bit
  logic [SEC_MSB:0]       sectors_left;    // count minus one
  logic [NEG_MSB:0]       negate_point;    // deassert point
  logic [9:0]             flash_byte_counter; // bytes left in block incl. checksum
  logic                   resume_pend;     // sector end held back by a fault
  logic [1:0]             pulse_cnt;       // pulse width counter
  logic                   level_req;       // level mode request
  logic [5:0]             irq_stat;        // sticky events
  logic [5:0]             irq_en;          // enables
  logic                   rd_ack;
  logic [15:0]            rd_data;
  logic                   req_pin;
  logic [8*BUS_BYTES-1:0] out_data;

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  logic wr_pri, wr_neg, wr_clr, wr_en;
  logic beat, sector_end, last_sector, fault, finish, advance, start_block;
  logic [9:0] next_count;

  // write strobe for one offset
  function automatic logic hit(input logic [12:0] ofs);
    hit = link.reg_cs && link.reg_we && (link.reg_addr == ofs);
  endfunction : hit

  always_comb begin
    wr_pri      = hit(OFS_CTRL_PRI);
    wr_neg      = hit(OFS_CTRL_NEG);
    wr_clr      = hit(OFS_IRQ_CLR);
    wr_en       = hit(OFS_IRQ_EN);
    // beats are only honoured while running; a stray strobe is ignored
    beat        = link.dma_rd && dma_en && !pause && (flash_byte_counter != 10'h000);
    next_count  = (flash_byte_counter > STEP) ? flash_byte_counter - STEP : 10'h000;
    sector_end  = beat && (next_count == 10'h000);   // checksum bytes just read
    fault       = sector_end && i_ecc_err;
    // a cleared pause completes the held sector end
    advance     = (sector_end && !i_ecc_err) ||
                  (resume_pend && !pause && dma_en);
    last_sector = (sectors_left == '0);
    finish      = advance && last_sector;
    // new block on arming, and after each sector that is not the last
    start_block = (wr_pri && link.reg_wdata[EN_BIT] && !dma_en) ||
                  (advance && !last_sector);
  end

  // --------------------------------------------------------------
  // primary control word
  // --------------------------------------------------------------
  // enable and mode bits; enable drops by itself at completion
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dma_en    <= CTRL_RST[EN_BIT];
      pulse_sel <= CTRL_RST[PULSE_BIT];
      req_pol   <= CTRL_RST[POL_BIT];
    end else begin
      if (wr_pri) begin
        dma_en    <= link.reg_wdata[EN_BIT];
        pulse_sel <= link.reg_wdata[PULSE_BIT];
        req_pol   <= link.reg_wdata[POL_BIT];
      end
      if (finish) begin
        dma_en <= 1'b0;
      end
    end
  end

  // pause: hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pause <= CTRL_RST[PAUSE_BIT];
    end else if (fault && dma_en) begin
      pause <= 1'b1;
    end else if (wr_pri && !link.reg_wdata[PAUSE_BIT]) begin
      pause <= 1'b0;
    end
  end

  // remembers a faulted sector so its count step happens on resume
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      resume_pend <= 1'b0;
    end else if (fault) begin
      resume_pend <= 1'b1;
    end else if (advance || !dma_en) begin
      resume_pend <= 1'b0;
    end
  end

  // sectors left: loaded by software, stepped per clean checksum and on resume
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sectors_left <= CTRL_RST[SEC_MSB:0];
    end else if (wr_pri) begin
      sectors_left <= link.reg_wdata[SEC_MSB:0];
    end else if (advance && !last_sector) begin
      sectors_left <= sectors_left - 1'b1;         // held on fault
    end
  end

  // deassert point
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      negate_point <= CTRL_RST[NEG_MSB:0];
    end else if (wr_neg) begin
      negate_point <= link.reg_wdata[NEG_MSB:0];
    end
  end

  // --------------------------------------------------------------
  // byte counter and request generation
  // --------------------------------------------------------------
  // counts down the sector plus its checksum bytes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flash_byte_counter <= 10'h000;
    end else if (start_block) begin
      flash_byte_counter <= BLOCK_BYTES;
    end else if (!dma_en || (wr_pri && !link.reg_wdata[EN_BIT])) begin
      flash_byte_counter <= 10'h000;               // disarm aborts the block
    end else if (beat) begin
      flash_byte_counter <= next_count;
    end
  end

  // pulse mode: fixed width active pulse per block
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pulse_cnt <= 2'h0;
    end else if (start_block && pulse_sel_next()) begin
      pulse_cnt <= PULSE_CYC;
    end else if (pulse_cnt != 2'h0) begin
      pulse_cnt <= pulse_cnt - 2'h1;
    end
  end

  // level mode: active from block start until the counter hits the point
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      level_req <= 1'b0;
    end else if (start_block && !pulse_sel_next()) begin
      level_req <= 1'b1;
    end else if (!dma_en || pause ||
                 (beat && (next_count[NEG_MSB:0] == negate_point))) begin
      level_req <= 1'b0;
    end
  end

  // mode seen by a block started in the same cycle as the write
  function automatic logic pulse_sel_next();
    pulse_sel_next = wr_pri ? link.reg_wdata[PULSE_BIT] : pulse_sel;
  endfunction : pulse_sel_next

  // pin level: idle is the inverse of the polarity bit; the output flop
  // keeps the pin glitch free when polarity is rewritten
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_pin <= ~CTRL_RST[POL_BIT];
    end else if (dma_en && (level_req || pulse_cnt != 2'h0)) begin
      req_pin <= req_pol;
    end else begin
      req_pin <= ~req_pol;
    end
  end

  // data for each beat, one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_data <= '0;
    end else if (beat) begin
      out_data <= i_flash_data;
    end
  end

  // --------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------
  // sticky events; an event in the clearing cycle survives
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_stat <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if ((i == ECC_EV_BIT && fault && dma_en) ||
            (i == DONE_EV_BIT && finish)) begin
          irq_stat[i] <= 1'b1;
        end else if (wr_clr && link.reg_wdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  // enables
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_en <= 6'h00;
    end else if (wr_en) begin
      irq_en <= link.reg_wdata[5:0];
    end
  end

  // level interrupt, registered
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat & irq_en);
    end
  end

  // busy
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= dma_en && !pause;
    end
  end

  // --------------------------------------------------------------
  // register reads: answer one cycle after every access
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_ack  <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rd_ack <= link.reg_cs;
      unique case (link.reg_addr)
        OFS_CTRL_PRI: rd_data <= {dma_en, pause, pulse_sel, req_pol, 5'h00, sectors_left};
        OFS_CTRL_NEG: rd_data <= {6'h00, negate_point};
        OFS_IRQ_STAT: rd_data <= {10'h000, irq_stat};
        OFS_IRQ_EN:   rd_data <= {10'h000, irq_en};
        default:      rd_data <= 16'h0000;         // unmapped and write-only read zero
      endcase
    end
  end

  assign link.reg_ack              = rd_ack;
  assign link.reg_rdata            = rd_data;
  assign link.transfer_request_out = req_pin;
  assign link.dma_data             = out_data;
endmodule : sdr_dev
`default_nettype wire

// ### logic/sdr_pkg.sv
// shared constants for the sector dma request link
package sdr_pkg;
  // --------------------------------------------------------------
  // device register map (13-bit window offsets)
  // --------------------------------------------------------------
  localparam logic [12:0] OFS_CTRL_PRI   = 13'h1078; // dma_control_primary
  localparam logic [12:0] OFS_CTRL_NEG   = 13'h107a; // dma_control_deassert_point
  localparam logic [12:0] OFS_IRQ_STAT   = 13'h1020; // sticky event status, read only
  localparam logic [12:0] OFS_IRQ_CLR    = 13'h1080; // write one to clear, write only
  localparam logic [12:0] OFS_IRQ_EN     = 13'h1082; // interrupt enable
  localparam logic [15:0] CTRL_RST       = 16'h0000; // reset value of both control words
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int          SEC_MSB        = 6;        // sectors-left field 6..0
  localparam int          POL_BIT        = 12;       // request_polarity_bit
  localparam int          PULSE_BIT      = 13;       // pulse select
  localparam int          PAUSE_BIT      = 14;       // pause
  localparam int          EN_BIT         = 15;       // transfer enable
  localparam int          NEG_MSB        = 9;        // deassert point 9..0
  localparam int          ECC_EV_BIT     = 3;        // correction-code error event
  localparam int          DONE_EV_BIT    = 5;        // dma completion event
  // --------------------------------------------------------------
  // sector geometry and timing
  // --------------------------------------------------------------
  localparam int          SECTOR_BYTES   = 512;
  localparam int          CHECK_BYTES    = 16;
  localparam logic [9:0]  BLOCK_BYTES    = 10'(SECTOR_BYTES + CHECK_BYTES);
  localparam int          CLK_NS         = 100;      // 10 MHz
  localparam int          PULSE_NS       = 250;      // request pulse width, rounded up to whole clocks (300 ns)
  localparam logic [1:0]  PULSE_CYC      = 2'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  // --------------------------------------------------------------
  // host avalon register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [4:0]  AV_CMD         = 5'h00;    // bit0 go, bit1 write
  localparam logic [4:0]  AV_ADDR        = 5'h04;    // device offset
  localparam logic [4:0]  AV_WDATA       = 5'h08;    // device write data
  localparam logic [4:0]  AV_RESULT      = 5'h0c;    // read data, bit16 busy
  localparam logic [4:0]  AV_DMA_CFG     = 5'h10;    // bit0 answer requests, bit1 polarity
  localparam logic [4:0]  AV_DMA_STAT    = 5'h14;    // beats moved, bit31 block active
  localparam logic [4:0]  AV_DMA_DATA    = 5'h18;    // last word moved
endpackage : sdr_pkg

// ### logic/sdr_if.sv
// link between the flash disk dma end and the host dma controller end
`timescale 1ns/10ps
`default_nettype none
interface sdr_if #(parameter int BUS_BYTES = 2);
  logic                   reg_cs;        // one-cycle register access strobe
  logic                   reg_we;        // access is a write
  logic [12:0]            reg_addr;      // window offset
  logic [15:0]            reg_wdata;     // write data
  logic                   reg_ack;       // one-cycle answer
  logic [15:0]            reg_rdata;     // read data, valid with ack
  logic                   transfer_request_out; // request pin, polarity programmable
  logic                   dma_rd;        // one bus cycle of bus_cycle_byte_width bytes
  logic [8*BUS_BYTES-1:0] dma_data;      // data for the previous dma_rd
  modport dev  (input reg_cs, reg_we, reg_addr, reg_wdata, dma_rd,
                output reg_ack, reg_rdata, transfer_request_out, dma_data);
  modport host (output reg_cs, reg_we, reg_addr, reg_wdata, dma_rd,
                input reg_ack, reg_rdata, transfer_request_out, dma_data);
endinterface : sdr_if
`default_nettype wire

// ### logic/sdr_host.sv
// host end: avalon-mm command port, register access and dma block mover
`timescale 1ns/10ps
`default_nettype none
module sdr_host #(
  parameter int BUS_BYTES = 2                       // bus_cycle_byte_width
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  sdr_if.host              link,
  input  wire logic [4:0]  i_avs_address,           // byte address
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  import sdr_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  localparam logic [9:0] BEATS = 10'(BLOCK_BYTES / 10'(BUS_BYTES)); // beats per block
  logic        cs, we, busy;
  logic [12:0] addr;
  logic [15:0] wdata, result;
  logic        ans_en, pol;                          // dma answer enable, polarity copy
  logic        act_d;                                // last request level
  logic [9:0]  beats_left;
  logic        rd_stb, rd_pend;
  logic [30:0] beats_done;
  logic [8*BUS_BYTES-1:0] last_data;
  logic        acc, wr_hit, act;

  always_comb begin
    acc    = (i_avs_read || i_avs_write) && o_avs_waitrequest;
    wr_hit = acc && i_avs_write;
    act    = link.transfer_request_out == pol;
  end

  // --------------------------------------------------------------
  // avalon slave: waitrequest drops in the second cycle of a request
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= !acc;
      unique case (i_avs_address)
        AV_ADDR:     o_avs_readdata <= {19'h00000, addr};
        AV_WDATA:    o_avs_readdata <= {16'h0000, wdata};
        AV_RESULT:   o_avs_readdata <= {15'h0000, busy, result};
        AV_DMA_CFG:  o_avs_readdata <= {30'h0000_0000, pol, ans_en};
        AV_DMA_STAT: o_avs_readdata <= {beats_left != 10'h000, beats_done};
        AV_DMA_DATA: o_avs_readdata <= 32'(last_data);
        default:     o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------
  // device register access; a go while busy is dropped
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr   <= 13'h0000;
      wdata  <= 16'h0000;
      cs     <= 1'b0;
      we     <= 1'b0;
      busy   <= 1'b0;
      result <= 16'h0000;
    end else begin
      cs <= 1'b0;
      if (wr_hit && i_avs_address == AV_ADDR) begin
        addr <= i_avs_writedata[12:0];
      end
      if (wr_hit && i_avs_address == AV_WDATA) begin
        wdata <= i_avs_writedata[15:0];              // pause clear goes here
      end
      if (wr_hit && i_avs_address == AV_CMD && i_avs_writedata[0] && !busy) begin
        cs   <= 1'b1;
        we   <= i_avs_writedata[1];
        busy <= 1'b1;
      end else if (link.reg_ack) begin
        busy   <= 1'b0;
        result <= link.reg_rdata;
      end
    end
  end

  // dma configuration is a separate copy that software keeps in step with the device
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ans_en <= 1'b0;
      pol    <= 1'b0;
    end else if (wr_hit && i_avs_address == AV_DMA_CFG) begin
      ans_en <= i_avs_writedata[0];
      pol    <= i_avs_writedata[1];
    end
  end

  // --------------------------------------------------------------
  // block mover: one block of beats per request assertion
  // --------------------------------------------------------------
  // works for pulse and level requests alike, since only the edge is used
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_d      <= 1'b0;
      beats_left <= 10'h000;
      rd_stb     <= 1'b0;
      rd_pend    <= 1'b0;
      beats_done <= 31'h0000_0000;
      last_data  <= '0;
    end else begin
      act_d   <= act;
      rd_pend <= rd_stb;
      if (act && !act_d && ans_en && beats_left == 10'h000) begin
        beats_left <= BEATS;
        rd_stb     <= 1'b0;
      end else if (beats_left != 10'h000 && ans_en) begin
        rd_stb     <= 1'b1;
        beats_left <= beats_left - 10'h001;
      end else begin
        rd_stb     <= 1'b0;
        beats_left <= ans_en ? beats_left : 10'h000;
      end
      if (rd_pend) begin
        last_data  <= link.dma_data;
        beats_done <= beats_done + 31'h0000_0001;
      end
    end
  end

  assign link.reg_cs    = cs;
  assign link.reg_we    = we;
  assign link.reg_addr  = addr;
  assign link.reg_wdata = wdata;
  assign link.dma_rd    = rd_stb;
endmodule : sdr_host
`default_nettype wire

// ### dv/sdr_link_checker.sv
// concurrent checks on the sector dma request link
`timescale 1ns/10ps
`default_nettype none
module sdr_link_checker
  import sdr_pkg::*;
#(
  parameter int BUS_BYTES = 2
) (
  input wire logic                   i_clk,
  input wire logic                   i_rst,
  input wire logic                   reg_cs,
  input wire logic                   reg_we,
  input wire logic [12:0]            reg_addr,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_ack,
  input wire logic                   transfer_request_out,
  input wire logic                   dma_rd,
  input wire logic [8*BUS_BYTES-1:0] dma_data
);
  // ----------------------------------------------------------------
  // shadow of the control words, as last written over the link
  // ----------------------------------------------------------------
  logic       en_sh, pol_sh, pulse_sh, act_q; // enable, polarity, pulse select
  logic [9:0] neg_sh;                          // deassert point
  logic [9:0] nb;                              // beats since request went active
  // hardware clears enable at the end, so act leans on the pin as well
  wire logic       act    = en_sh && (transfer_request_out == pol_sh);
  wire logic [9:0] exp_nb = 10'((BLOCK_BYTES - neg_sh) / BUS_BYTES + 1);
  // capture primary control writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {en_sh, pol_sh, pulse_sh} <= 3'h0;
    end else if (reg_cs && reg_we && reg_addr == OFS_CTRL_PRI) begin
      {en_sh, pol_sh, pulse_sh} <= {reg_wdata[EN_BIT], reg_wdata[POL_BIT], reg_wdata[PULSE_BIT]};
    end
  end
  // capture deassert point writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      neg_sh <= 10'h000;
    end else if (reg_cs && reg_we && reg_addr == OFS_CTRL_NEG) begin
      neg_sh <= reg_wdata[NEG_MSB:0];
    end
  end
  // beat counter restarted by every new request
  always_ff @(posedge i_clk) begin
    act_q <= act;
    if (act && !act_q) begin
      nb <= 10'h000;
    end else if (dma_rd) begin
      nb <= nb + 10'h001;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_pulse;
    act [*3] ##1 !act;
  endsequence
  sequence s_hold;
    act [*8];
  endsequence
  a_ack_after_cs: assert property (reg_cs |=> reg_ack) else $error("no ack after access");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_cs)) else $error("ack without access");
  a_data_holds: assert property (!dma_rd |=> $stable(dma_data)) else $error("data moved without beat");
  a_idle_level: assert property (!en_sh && !$past(en_sh) && $stable(pol_sh) |-> transfer_request_out != pol_sh)
    else $error("request pin not idle");
  a_pulse_width: assert property ($rose(act) && pulse_sh |-> s_pulse) else $error("bad pulse width");
  a_level_holds: assert property ($rose(act) && !pulse_sh |-> s_hold) else $error("level request short");
  a_req_ends: assert property ($rose(act) |-> ##[1:600] !act) else $error("request never released");
  a_level_drop: assert property ($fell(act) && !pulse_sh |-> nb == exp_nb || nb == exp_nb + 10'h001)
    else $error("level release at wrong beat");
endmodule : sdr_link_checker
`default_nettype wire

// ### dv/sector_dma_request_control_tb_top.sv
// self-checking bench for both ends of the sector dma request link
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module sector_dma_request_control_tb_top;
  import sdr_pkg::*;
  logic        i_clk, i_rst, ecc, irq, busy, avs_rd, avs_wr, wait_rq; // bench-driven and observed
  logic [4:0]  avs_a;                                                 // avalon byte address
  logic [31:0] avs_wd, avs_q, q;                                      // avalon data, last read
  logic [15:0] v;                                                     // last device register read
  int          bad_count, n_checks;
  sdr_if #(.BUS_BYTES(2)) i_sdr_if ();
  sdr_dev #(.BUS_BYTES(2)) i_sdr_dev (.i_clk(i_clk), .i_rst(i_rst), .link(i_sdr_if), .i_flash_data(16'h5a3c),
    .i_ecc_err(ecc), .o_irq(irq), .o_busy(busy));
  sdr_host #(.BUS_BYTES(2)) i_sdr_host (.i_clk(i_clk), .i_rst(i_rst), .link(i_sdr_if), .i_avs_address(avs_a),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wd), .o_avs_readdata(avs_q),
    .o_avs_waitrequest(wait_rq));
  sdr_link_checker #(.BUS_BYTES(2)) i_sdr_link_checker (.i_clk(i_clk), .i_rst(i_rst), .reg_cs(i_sdr_if.reg_cs),
    .reg_we(i_sdr_if.reg_we), .reg_addr(i_sdr_if.reg_addr), .reg_wdata(i_sdr_if.reg_wdata),
    .reg_ack(i_sdr_if.reg_ack), .transfer_request_out(i_sdr_if.transfer_request_out),
    .dma_rd(i_sdr_if.dma_rd), .dma_data(i_sdr_if.dma_data));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // one avalon access held until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_a <= a;
    avs_wr <= w;
    avs_rd <= !w;
    avs_wd <= d;
    do @(posedge i_clk); while (wait_rq !== 1'b0);
    q = avs_q;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    @(posedge i_clk); // gap so the strobe is never re-raised in the same step
  endtask : av
  // device register access through the host command port
  task automatic dacc(input logic w, input logic [12:0] o, input logic [15:0] d);
    av(1'b1, AV_ADDR, {19'h0, o});
    av(1'b1, AV_WDATA, {16'h0, d});
    av(1'b1, AV_CMD, {30'h0, w, 1'b1});
    do av(1'b0, AV_RESULT, 32'h0); while (q[16] !== 1'b0);
    v = q[15:0];
  endtask : dacc
  // wait until busy is low: the device is disarmed or paused
  task automatic wait_idle();
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge i_clk);
    `CHK(busy, 1'b0) // a run that never stops is a mismatch
  endtask : wait_idle
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // whole run is a few thousand cycles; this is several times that
  initial begin
    repeat (30000) @(posedge i_clk);
    bad_count++;
    conclude();
  end
  initial begin
    {i_rst, ecc, avs_rd, avs_wr, avs_a, avs_wd} = {1'b1, 3'h0, 5'h00, 32'h0};
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    dacc(1'b0, OFS_CTRL_PRI, 16'h0); `CHK(v, CTRL_RST)
    dacc(1'b0, OFS_CTRL_NEG, 16'h0); `CHK(v, CTRL_RST)
    dacc(1'b0, 13'h0100, 16'h0); `CHK(v, 16'h0000)
    av(1'b0, 5'h1c, 32'h0); `CHK(q, 32'h0)
    `CHK(i_sdr_if.transfer_request_out, 1'b1)
    // armed host, device disabled: nothing may move
    av(1'b1, AV_DMA_CFG, 32'h1);
    dacc(1'b1, OFS_CTRL_PRI, 16'h2001);
    repeat (50) @(posedge i_clk);
    av(1'b0, AV_DMA_STAT, 32'h0); `CHK(q, 32'h0)
    // two sectors, pulse mode, done interrupt enabled
    dacc(1'b1, OFS_IRQ_EN, 16'h0028);
    dacc(1'b1, OFS_CTRL_PRI, 16'ha001);
    repeat (300) @(posedge i_clk);
    dacc(1'b0, OFS_CTRL_PRI, 16'h0); `CHK(v, 16'ha000)
    wait_idle();
    dacc(1'b0, OFS_CTRL_PRI, 16'h0); `CHK(v, 16'h2000)
    // two blocks of two-byte beats, none left in flight
    av(1'b0, AV_DMA_STAT, 32'h0); `CHK(q, {1'b0, 31'(2 * (SECTOR_BYTES + CHECK_BYTES) / 2)})
    av(1'b0, AV_DMA_DATA, 32'h0); `CHK(q[15:0], 16'h5a3c)
    dacc(1'b0, OFS_IRQ_STAT, 16'h0); `CHK(v, 16'h0020)
    `CHK(irq, 1'b1)
    dacc(1'b1, OFS_IRQ_CLR, 16'h0020); `CHK(irq, 1'b0)
    // three sectors with a checksum fault on the first
    dacc(1'b1, OFS_IRQ_EN, 16'h0008);
    ecc <= 1'b1;
    dacc(1'b1, OFS_CTRL_PRI, 16'ha002);
    wait_idle();
    dacc(1'b0, OFS_CTRL_PRI, 16'h0); `CHK(v, 16'he002)
    dacc(1'b0, OFS_IRQ_STAT, 16'h0); `CHK(v, 16'h0008)
    `CHK(irq, 1'b1)
    ecc <= 1'b0;
    dacc(1'b1, OFS_IRQ_CLR, 16'h0008);
    dacc(1'b1, OFS_CTRL_PRI, 16'ha002);
    wait_idle();
    dacc(1'b0, OFS_CTRL_PRI, 16'h0); `CHK(v[15:14], 2'b00)
    dacc(1'b0, OFS_IRQ_STAT, 16'h0); `CHK(v, 16'h0020)
    `CHK(irq, 1'b0)
    // level mode, active-high pin, release 20 bytes before the end
    // host stops answering while the two polarity copies disagree, or the
    // mismatch looks like a request edge and starts a stray block
    av(1'b1, AV_DMA_CFG, 32'h2);
    dacc(1'b1, OFS_CTRL_PRI, 16'h1000); `CHK(i_sdr_if.transfer_request_out, 1'b0)
    av(1'b1, AV_DMA_CFG, 32'h3);
    dacc(1'b1, OFS_CTRL_NEG, 16'h0014);
    dacc(1'b1, OFS_CTRL_PRI, 16'h9000); `CHK(i_sdr_if.transfer_request_out, 1'b1)
    wait_idle();
    dacc(1'b0, OFS_CTRL_PRI, 16'h0); `CHK(v, 16'h1000)
    `CHK(i_sdr_if.transfer_request_out, 1'b0)
    conclude();
  end
endmodule : sector_dma_request_control_tb_top
`default_nettype wire
